//--- hdl/flag_offset_pkg.sv
/*
   shared constants and types for the flag offset programming block:
   register offsets, field widths, reset values and preset offset table.
   assumes a 32-bit Avalon-MM slave and a 72-bit data port.
*/
package flag_offset_pkg;

   // widths of the data port, offsets, word counter and serial pointer
   localparam int DATA_W = 72;
   localparam int OFS_W  = 17;
   localparam int CNT_W  = 18;
   localparam int BIT_W  = 6;
   localparam int ADDR_W = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CONTROL_ADDR      = 5'h00;
   localparam logic [ADDR_W-1:0] STATUS_ADDR       = 5'h04;
   localparam logic [ADDR_W-1:0] WORDS_ADDR        = 5'h08;
   localparam logic [ADDR_W-1:0] EMPTY_OFFSET_ADDR = 5'h0C;
   localparam logic [ADDR_W-1:0] FULL_OFFSET_ADDR  = 5'h10;

   // control register: depth select field and its reset value
   localparam int            DEPTH_SEL_LSB   = 0;
   localparam logic [1:0]    DEPTH_SEL_RESET = 2'h3;

   // smallest depth and smallest offset width
   localparam logic [CNT_W-1:0] BASE_DEPTH   = 18'h04000;
   localparam logic [BIT_W-1:0] BASE_OFS_W   = 6'h0E;
   localparam logic [OFS_W-1:0] FULL_OFS_MASK = 17'h1FFFF;

   // edges of the flag clock that follow completion before a flag is valid
   localparam logic [1:0] SERIAL_SETTLE   = 2'h3;
   localparam logic [1:0] PARALLEL_SETTLE = 2'h2;

   // preset offsets indexed by {load select, preset 1, preset 0}
   localparam logic [7:0][OFS_W-1:0] PRESET_OFS = {
      17'h00007, 17'h0001F, 17'h0000F, 17'h003FF,
      17'h0003F, 17'h001FF, 17'h000FF, 17'h0007F};

   // flag bits as seen on the pins and in the status register
   typedef struct packed {
      logic outputValidN;
      logic almostEmpty;
      logic halfFull;
      logic almostFull;
      logic inputReady;
   } flags_t;

   localparam flags_t FLAGS_RESET = '{outputValidN: 1'b1, almostEmpty: 1'b0,
                                      halfFull: 1'b1, almostFull: 1'b1,
                                      inputReady: 1'b0};

endpackage

//--- hdl/fifo_flag_offset_programming.sv
/*
   flag offset programming, readback and fall-through flag decode for a
   dual-clock 72-bit FIFO, plus a small Avalon-MM register slave.
   assumes all pins, including the write, read and serial clocks, are
   asynchronous to sys_clk and much slower than it; they are sampled here.
*/
// The register addresses and register access over Avalon-MM are this design's own decisions.
// Notes on behaviour
// - empty and 1..n+1 words flag pattern
// - parallel writes store offsets in order
// - parallel reads present offsets in order
// - serial shift one bit per serial clock
// - serial flags invalid until full bit set
// - serial enable high blocks serial writes
// - serial programming pauses and resumes in sequence
// - serial completion: flags valid after three edges
// - offsets readable in parallel under either method
// - separate offset write and read pointers
// - master reset clears pointers, partial keeps them
// - parallel programming pauses and resumes in sequence
// - parallel flag invalid until its word written
// - parallel completion: flags valid after two edges
// - readback takes two reads, empty first
// - readback pauses and resumes where it stopped
// - offset read overwrites output bus
// - readback works in both timing modes
// - master reset samples load select for method
// - master reset loads one of eight presets
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for a group of asynchronous pins
module sync_bits #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] async,
   output logic      [W-1:0] synced
);
   logic [W-1:0] stage1;

   // first stage feeds only the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= '0;
         synced <= '0;
      end else begin
         stage1 <= async;
         synced <= stage1;
      end
   end
endmodule // sync_bits

module fifo_flag_offset_programming
   import flag_offset_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic              master_reset_n,
   input  wire logic              partial_reset_n,
   input  wire logic              load_select,
   input  wire logic              serial_enable_n,
   input  wire logic              write_enable_n,
   input  wire logic              read_enable_n,
   input  wire logic              write_clock,
   input  wire logic              read_clock,
   input  wire logic              serial_clock,
   input  wire logic              serial_in,
   input  wire logic              preset_select_0,
   input  wire logic              preset_select_1,
   input  wire logic              fall_through_mode,
   input  wire logic [DATA_W-1:0] data_in_bus,
   output logic      [DATA_W-1:0] data_out_bus,
   output logic                   input_ready_flag,
   output logic                   almost_full_flag,
   output logic                   half_full_flag,
   output logic                   almost_empty_flag,
   output logic                   output_valid_flag,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [31:0]       readdata,
   output logic                   waitrequest
);

   logic [12:0]       pinSync;
   logic [DATA_W-1:0] dataSync;
   logic [2:0]        clkPrev;
   logic              serialMode;
   logic              wrPtr;
   logic              rdPtr;
   logic [BIT_W-1:0]  bitPtr;
   logic [33:0]       shadow;
   logic [OFS_W-1:0]  emptyOfs;
   logic [OFS_W-1:0]  fullOfs;
   logic              emptyValid;
   logic              fullValid;
   logic [1:0]        emptyWait;
   logic [1:0]        fullWait;
   logic [CNT_W-1:0]  words;
   logic [1:0]        depthSel;
   flags_t            flags;

   // pin inputs pass two flip-flops before any logic reads them
   sync_bits #(.W(13)) pinSyncer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .async   ({master_reset_n, partial_reset_n, load_select, serial_enable_n,
                 write_enable_n, read_enable_n, write_clock, read_clock,
                 serial_clock, serial_in, preset_select_1, preset_select_0,
                 fall_through_mode}),
      .synced  (pinSync)
   );

   sync_bits #(.W(DATA_W)) dataSyncer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .async   (data_in_bus),
      .synced  (dataSync)
   );

   // named views of the sampled pins
   wire mrsActive = !pinSync[12];
   wire prsActive = !pinSync[11];
   wire ldS       = pinSync[10];
   wire senNS     = pinSync[9];
   wire wenNS     = pinSync[8];
   wire renNS     = pinSync[7];
   wire wclkS     = pinSync[6];
   wire rclkS     = pinSync[5];
   wire sclkS     = pinSync[4];
   wire siS       = pinSync[3];
   wire fsel1S    = pinSync[2];
   wire fsel0S    = pinSync[1];
   wire fwftS     = pinSync[0];

   // rising edges of the sampled link clocks
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clkPrev <= '0;
      end else begin
         clkPrev <= {wclkS, rclkS, sclkS};
      end
   end

   wire wclkEdge = wclkS && !clkPrev[2];
   wire rclkEdge = rclkS && !clkPrev[1];
   wire sclkEdge = sclkS && !clkPrev[0];
   wire anyReset = mrsActive || prsActive;

   // operation decode from load select and the three enables
   wire ofsWrite  = wclkEdge && !ldS && !wenNS && renNS && senNS && !serialMode;
   wire ofsRead   = rclkEdge && !ldS && !renNS && wenNS && senNS;
   wire serShift  = sclkEdge && serialMode && !ldS && !senNS;
   wire memWrite  = wclkEdge && ldS && !wenNS;
   wire memRead   = rclkEdge && ldS && !renNS;

   // depth, offset width and serial length from the control register
   wire [CNT_W-1:0] depth     = CNT_W'(BASE_DEPTH << depthSel);
   wire [BIT_W-1:0] ofsWidth  = BASE_OFS_W + BIT_W'(depthSel);
   wire [BIT_W-1:0] lastBit   = BIT_W'({ofsWidth, 1'b0} - 7'h01);
   wire [OFS_W-1:0] ofsMask   = FULL_OFS_MASK >> (2'h3 - depthSel);
   wire [CNT_W-1:0] extra     = CNT_W'(fwftS);
   wire [CNT_W-1:0] capacity  = depth + extra;
   wire             serLast   = serShift && (bitPtr == lastBit);
   wire [OFS_W-1:0] shEmpty   = OFS_W'(shadow) & ofsMask;
   wire [OFS_W-1:0] shFull    = OFS_W'(shadow >> ofsWidth) & (ofsMask >> 1); // stale top bit out
   wire [OFS_W-1:0] dataOfs   = OFS_W'(dataSync) & ofsMask;
   wire [OFS_W-1:0] presetOfs = PRESET_OFS[{ldS, fsel1S, fsel0S}];

   // method is latched only while master reset is held
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         serialMode <= 1'b0;
      end else if (mrsActive) begin
         serialMode <= ldS;
      end
   end

   // offset write and read pointers; only master reset moves them home
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
      end else if (mrsActive) begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
      end else begin
         if (ofsWrite) begin
            wrPtr <= !wrPtr;
         end
         if (ofsRead) begin
            rdPtr <= !rdPtr;
         end
      end
   end

   // serial shadow register and its bit pointer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bitPtr <= '0;
         shadow <= '0;
      end else if (mrsActive) begin
         bitPtr <= '0;
         shadow <= '0;
      end else if (serShift) begin
         shadow[bitPtr] <= siS;
         bitPtr <= serLast ? '0 : bitPtr + 6'h01;
      end
   end

   // live offsets: presets at master reset, then serial commit or parallel write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         emptyOfs <= PRESET_OFS[0];
         fullOfs  <= PRESET_OFS[0];
      end else if (mrsActive) begin
         emptyOfs <= presetOfs;
         fullOfs  <= presetOfs;
      end else if (serLast) begin
         emptyOfs <= {shEmpty[OFS_W-1:1], siS && (bitPtr == '0)} | shEmpty;
         fullOfs  <= shFull | OFS_W'({siS, {(OFS_W-1){1'b0}}} >> (2'h3 - depthSel));
      end else if (ofsWrite) begin
         if (wrPtr) begin
            fullOfs <= dataOfs;
         end else begin
            emptyOfs <= dataOfs;
         end
      end
   end

   // almost-empty validity, timed on read clock edges
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         emptyValid <= 1'b1;
         emptyWait  <= '0;
      end else if (mrsActive) begin
         emptyValid <= 1'b1;
         emptyWait  <= '0;
      end else if (serShift && bitPtr == '0) begin
         emptyValid <= 1'b0;
         emptyWait  <= serLast ? SERIAL_SETTLE : 2'h0;
      end else if (serLast) begin
         emptyWait  <= SERIAL_SETTLE;
      end else if (ofsWrite && !wrPtr) begin
         emptyValid <= 1'b0;
         emptyWait  <= PARALLEL_SETTLE;
      end else if (rclkEdge && emptyWait != 2'h0) begin
         emptyWait  <= emptyWait - 2'h1;
         emptyValid <= (emptyWait == 2'h1);
      end
   end

   // almost-full validity, timed on write clock edges
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fullValid <= 1'b1;
         fullWait  <= '0;
      end else if (mrsActive) begin
         fullValid <= 1'b1;
         fullWait  <= '0;
      end else if (serShift && bitPtr == '0) begin
         fullValid <= 1'b0;
         fullWait  <= serLast ? SERIAL_SETTLE : 2'h0;
      end else if (serLast) begin
         fullWait  <= SERIAL_SETTLE;
      end else if (ofsWrite && wrPtr) begin
         fullValid <= 1'b0;
         fullWait  <= PARALLEL_SETTLE;
      end else if (wclkEdge && fullWait != 2'h0) begin
         fullWait  <= fullWait - 2'h1;
         fullValid <= (fullWait == 2'h1);
      end
   end

   // occupancy of the FIFO memory; either reset empties it
   wire canWrite = memWrite && (words != capacity);
   wire canRead  = memRead && (words != '0);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         words <= '0;
      end else if (anyReset) begin
         words <= '0;
      end else if (canWrite && !canRead) begin
         words <= words + 18'h00001;
      end else if (canRead && !canWrite) begin
         words <= words - 18'h00001;
      end
   end

   // flag thresholds; fall-through shifts every boundary but empty up by one word
   wire [CNT_W-1:0] aeLimit = CNT_W'(emptyOfs) + extra;
   wire [CNT_W-1:0] hfLimit = (depth >> 1) + 18'h00001 + extra;
   wire [CNT_W-1:0] afLimit = depth - CNT_W'(fullOfs) + extra;
   wire             isEmpty = (words == '0);
   wire             isFull  = (words == capacity);
   flags_t          nextFlags;

   assign nextFlags.outputValidN = fwftS ? isEmpty : !isEmpty;
   assign nextFlags.almostEmpty  = emptyValid ? (words > aeLimit) : 1'b1;
   assign nextFlags.halfFull     = !(words >= hfLimit);
   assign nextFlags.almostFull   = fullValid ? !(words >= afLimit) : 1'b1;
   assign nextFlags.inputReady   = fwftS ? isFull : !isFull;

   // registered flags drive the pins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flags <= FLAGS_RESET;
      end else if (anyReset) begin
         flags <= '{outputValidN: fwftS, almostEmpty: 1'b0, halfFull: 1'b1,
                    almostFull: 1'b1, inputReady: !fwftS};
      end else begin
         flags <= nextFlags;
      end
   end

   assign output_valid_flag = flags.outputValidN;
   assign almost_empty_flag = flags.almostEmpty;
   assign half_full_flag    = flags.halfFull;
   assign almost_full_flag  = flags.almostFull;
   assign input_ready_flag  = flags.inputReady;

   // output bus: cleared by either reset, overwritten by offset reads
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         data_out_bus <= '0;
      end else if (anyReset) begin
         data_out_bus <= '0;
      end else if (ofsRead) begin
         data_out_bus <= DATA_W'(rdPtr ? fullOfs : emptyOfs);
      end
   end

   // register bus decode; one wait state on every access
   wire        busTake   = (read || write) && waitrequest;
   wire        hitCtrl   = (address == CONTROL_ADDR);
   wire [31:0] statusVal = {24'h000000, fullValid, emptyValid, serialMode,
                            flags.outputValidN, flags.almostEmpty, flags.halfFull,
                            flags.almostFull, flags.inputReady};
   wire [31:0] readMux   = hitCtrl                        ? {30'h0, depthSel} :
                           (address == STATUS_ADDR)       ? statusVal :
                           (address == WORDS_ADDR)        ? 32'(words) :
                           (address == EMPTY_OFFSET_ADDR) ? 32'(emptyOfs) :
                           (address == FULL_OFFSET_ADDR)  ? 32'(fullOfs) : 32'h0;
   wire        ctrlWrite = write && !waitrequest && hitCtrl && byteenable[0];

   // wait state, read data and the control register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         waitrequest <= 1'b1;
         readdata    <= '0;
         depthSel    <= DEPTH_SEL_RESET;
      end else begin
         waitrequest <= !busTake;
         if (busTake && read) begin
            readdata <= readMux;
         end
         if (ctrlWrite) begin
            depthSel <= writedata[DEPTH_SEL_LSB +: 2];
         end
      end
   end

endmodule // fifo_flag_offset_programming

`default_nettype wire

//--- test/fifo_flag_offset_properties.sv
/* checker of bus answers and flag and output relations of the block.
   assumes it is bound onto fifo_flag_offset_programming. */
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_offset_properties
   import flag_offset_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rstn,
   input wire logic              master_reset_n,
   input wire logic              partial_reset_n,
   input wire logic              load_select,
   input wire logic              read_enable_n,
   input wire logic              fall_through_mode,
   input wire logic [DATA_W-1:0] data_out_bus,
   input wire logic              input_ready_flag,
   input wire logic              almost_full_flag,
   input wire logic              half_full_flag,
   input wire logic              almost_empty_flag,
   input wire logic              output_valid_flag,
   input wire logic [ADDR_W-1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [31:0]       readdata,
   input wire logic              waitrequest
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // bus answers after exactly one wait state
   wait_one_cycle_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer not after one wait state");
   wait_has_cause_a: assert property (!waitrequest |-> $past(read || write))
      else $error("bus answer without request");
   unmapped_reads_zero_a: assert property (
      read && !waitrequest && address > FULL_OFFSET_ADDR |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   readdata_holds_a: assert property ($changed(readdata) |-> $past((read || write) && waitrequest))
      else $error("read data changed without access");
   // flag pattern of an empty queue in fall-through mode
   empty_flag_set_a: assert property (
      fall_through_mode && output_valid_flag && master_reset_n
      |-> !input_ready_flag && half_full_flag && almost_full_flag)
      else $error("empty flag pattern wrong");
   // a new nonzero output word only comes from an offset read
   offset_read_only_a: assert property (
      $changed(data_out_bus) && data_out_bus != '0 |-> !read_enable_n && !load_select)
      else $error("output bus changed outside offset read");
   reset_pattern_a: assert property (
      !master_reset_n [*6] |-> data_out_bus == '0 && !almost_empty_flag && half_full_flag
      && output_valid_flag == fall_through_mode && input_ready_flag == !fall_through_mode)
      else $error("master reset pattern wrong");
   partial_clear_a: assert property (
      !partial_reset_n [*6] |-> data_out_bus == '0 && !almost_empty_flag)
      else $error("partial reset pattern wrong");

   // main scenarios reached
   serial_mode_c: cover property (read && !waitrequest && address == STATUS_ADDR && readdata[5]);
   almost_empty_rise_c: cover property ($rose(almost_empty_flag) && master_reset_n);
   offset_read_c: cover property ($changed(data_out_bus) && data_out_bus != '0);
endmodule // fifo_flag_offset_properties

bind fifo_flag_offset_programming fifo_flag_offset_properties chk (.*);
`default_nettype wire

//--- test/pin_host.sv
/* host controller model driving the offset block's pins.
   assumes tasks are entered just after a sys_clk rising edge. */
`timescale 1ns/10ps
`default_nettype none
module pin_host
   import flag_offset_pkg::*;
(
   input  wire logic         sys_clk,
   output logic              master_reset_n,
   output logic              partial_reset_n,
   output logic              load_select,
   output logic              serial_enable_n,
   output logic              write_enable_n,
   output logic              read_enable_n,
   output logic              write_clock,
   output logic              read_clock,
   output logic              serial_clock,
   output logic              serial_in,
   output logic              preset_select_0,
   output logic              preset_select_1,
   output logic              fall_through_mode,
   output logic [DATA_W-1:0] data_in_bus
);
   // idle pins: memory side, nothing enabled, pin clocks still
   initial begin
      {master_reset_n, partial_reset_n, load_select} = 3'h7;
      {serial_enable_n, write_enable_n, read_enable_n} = 3'h7;
      {write_clock, read_clock, serial_clock, serial_in} = 4'h0;
      {preset_select_0, preset_select_1} = 2'h0;
      fall_through_mode = 1'b1;
      data_in_bus = '0;
   end

   // one pin clock period; ctl is {load, write_n, read_n, serial_n}
   task automatic pulse(input int sel, input logic [3:0] ctl, input logic si,
                        input logic [DATA_W-1:0] d);
      {load_select, write_enable_n, read_enable_n, serial_enable_n} <= ctl;
      serial_in <= si;
      data_in_bus <= d;
      repeat (6) @(posedge sys_clk);
      if (sel == 0) write_clock <= 1'b1;
      else if (sel == 1) read_clock <= 1'b1;
      else serial_clock <= 1'b1;
      repeat (6) @(posedge sys_clk);
      {write_clock, read_clock, serial_clock} <= 3'h0;
      {load_select, write_enable_n, read_enable_n, serial_enable_n} <= 4'hF;
      data_in_bus <= ~d; // released bus must not keep its value
      @(posedge sys_clk);
   endtask

   // reset pulse; the method is picked only while master reset is low
   task automatic reset_pins(input logic full, input logic ld);
      load_select <= ld;
      if (full) master_reset_n <= 1'b0;
      else partial_reset_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      {master_reset_n, partial_reset_n} <= 2'h3;
      repeat (4) @(posedge sys_clk);
      load_select <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask

   // serial bits from index lo up to hi - 1, empty offset LSB first
   task automatic shift(input logic [33:0] bits, input int lo, input int hi);
      for (int i = lo; i < hi; i++) pulse(2, 4'h6, bits[i], '0);
   endtask
endmodule // pin_host
`default_nettype wire

//--- test/tb_fifo_flag_offset_programming.sv
/* self-checking bench: register reads over the bus and pin sequences
   through the host model. assumes the package, design and model. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_fifo_flag_offset_programming
   import flag_offset_pkg::*;
;
   localparam logic [33:0] SER = {6'h0, 14'h0011, 14'h0003};
   logic              sys_clk = 1'b0;
   logic              rstn = 1'b0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic [31:0]       writedata = '0;
   logic [3:0]        byteenable = 4'hF;
   logic [31:0]       readdata, rd;
   logic              waitrequest;
   logic [DATA_W-1:0] data_in_bus, data_out_bus;
   logic master_reset_n, partial_reset_n, load_select, serial_enable_n, write_enable_n;
   logic read_enable_n, write_clock, read_clock, serial_clock, serial_in;
   logic preset_select_0, preset_select_1, fall_through_mode;
   logic input_ready_flag, almost_full_flag, half_full_flag, almost_empty_flag;
   logic output_valid_flag;
   int   error_cnt = 0;
   int   num_checks = 0;
   int   cycles = 0;

   pin_host host (.*);
   fifo_flag_offset_programming DUT (.*);

   always #5 sys_clk = ~sys_clk;

   // cycle ceiling for the whole run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         report_and_stop;
      end
   end

   // bus access held until waitrequest is seen low at an edge
   task automatic bus_io(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [31:0] wd, output logic [31:0] d);
      address <= a;
      writedata <= wd;
      if (wr) write <= 1'b1;
      else read <= 1'b1;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      d = readdata;
      {read, write} <= 2'h0;
      @(posedge sys_clk);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      bus_io(1'b0, a, 32'h0, rd);
      `CHK(rd, e)
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      host.reset_pins(1'b1, 1'b0);
      rd_chk(EMPTY_OFFSET_ADDR, 32'h7F);
      rd_chk(FULL_OFFSET_ADDR, 32'h7F);
      rd_chk(5'h14, 32'h0);
      bus_io(1'b0, STATUS_ADDR, 32'h0, rd);
      `CHK(rd[5], 1'b0)
      `CHK({output_valid_flag, input_ready_flag, almost_empty_flag}, 3'h4)
      // parallel load broken by one memory write
      host.pulse(0, 4'h3, 1'b0, 72'h5);
      host.pulse(0, 4'hB, 1'b0, 72'h0);
      host.pulse(0, 4'h3, 1'b0, 72'h1FFFC);
      rd_chk(EMPTY_OFFSET_ADDR, 32'h5);
      rd_chk(FULL_OFFSET_ADDR, 32'h1FFFC);
      rd_chk(WORDS_ADDR, 32'h1);
      for (int k = 0; k < 3; k++) begin
         `CHK(almost_empty_flag, k < 2)
         if (k < 2) host.pulse(1, 4'hF, 1'b0, '0);
      end
      `CHK(output_valid_flag, 1'b0)
      // readback broken by a memory read
      host.pulse(1, 4'h5, 1'b0, '0);
      `CHK(data_out_bus, 72'h5)
      host.pulse(1, 4'hF, 1'b0, '0);
      host.pulse(1, 4'hD, 1'b0, '0);
      `CHK(data_out_bus, 72'h5)
      host.pulse(1, 4'hF, 1'b0, '0);
      host.pulse(1, 4'h5, 1'b0, '0);
      `CHK(data_out_bus, 72'h1FFFC)
      `CHK(output_valid_flag, 1'b1)
      // almost-empty rises at n+2 words, n = 5; almost-full falls at 5 words
      for (int k = 1; k <= 7; k++) begin
         host.pulse(0, 4'hB, 1'b0, 72'(k));
         `CHK({almost_empty_flag, output_valid_flag, almost_full_flag, half_full_flag}, {k == 7, 1'b0, k < 5, 1'b1})
      end
      // serial method with 14-bit offsets, paused midway
      host.reset_pins(1'b1, 1'b1);
      bus_io(1'b0, STATUS_ADDR, 32'h0, rd);
      `CHK(rd[5], 1'b1)
      rd_chk(EMPTY_OFFSET_ADDR, 32'h3FF);
      bus_io(1'b1, CONTROL_ADDR, 32'h0, rd);
      rd_chk(CONTROL_ADDR, 32'h0);
      host.pulse(0, 4'h3, 1'b0, 72'h55);
      rd_chk(EMPTY_OFFSET_ADDR, 32'h3FF);
      host.shift(SER, 0, 14);
      host.pulse(2, 4'h7, 1'b1, '0);
      host.pulse(0, 4'hB, 1'b0, '0);
      rd_chk(EMPTY_OFFSET_ADDR, 32'h3FF);
      bus_io(1'b0, STATUS_ADDR, 32'h0, rd);
      `CHK(rd[7:6], 2'h0)
      host.shift(SER, 14, 28);
      rd_chk(EMPTY_OFFSET_ADDR, 32'h3);
      rd_chk(FULL_OFFSET_ADDR, 32'h11);
      for (int k = 1; k <= 3; k++) begin
         host.pulse(0, 4'hF, 1'b0, '0);
         bus_io(1'b0, STATUS_ADDR, 32'h0, rd);
         `CHK(rd[7], k == 3)
      end
      // readback in serial mode across a partial reset
      host.pulse(1, 4'h5, 1'b0, '0);
      `CHK(data_out_bus, 72'h3)
      host.pulse(1, 4'hF, 1'b0, '0);
      // standard timing mode from here on
      host.fall_through_mode <= 1'b0;
      host.reset_pins(1'b0, 1'b1);
      `CHK(data_out_bus, 72'h0)
      `CHK({output_valid_flag, input_ready_flag}, 2'h1)
      host.pulse(1, 4'h5, 1'b0, '0);
      `CHK(data_out_bus, 72'h11)
      report_and_stop;
   end
endmodule // tb_fifo_flag_offset_programming
`default_nettype wire
